/* File: bench/tb.sv */
// Self-checking bench for the interrupt and transmit DMA register block
`timescale 1ns/1ps
module tb
  import uiet_pkg::*;
();
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] src = 32'h0000_0000;
  logic [31:0] irqVecIn = 32'h0000_0000;
  logic [31:0] dmaVecIn = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hready, hreadyout, hresp, irqPulse, eoiWrite, txDmaOn;
  logic tdReq, tdDone, dmaEoiWrite;
  logic [VEC_W-1:0] eoiVec, dmaEoiVec;
  logic [CHAN_W-1:0] tdChan;
  int miscompares = 0;
  int checksDone = 0;
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [31:0] s;
    logic [7:0] ra;
    logic [31:0] ex;
  } uiet_row_s;
  localparam uiet_row_s ROWS [9] = '{
    '{OFF_MCLR, 32'hFFFF_FFFF, 32'h01FF_1F1F, OFF_MASKED, 32'h0000_0000},
    '{OFF_MSET, 32'h0000_1F00, 32'h01AA_150A, OFF_MASKED, 32'h0000_1500},
    '{OFF_MSET, 32'hFFFF_FFFF, 32'h01AA_150A, OFF_MASKED, 32'h01AA_150A},
    '{OFF_MCLR, 32'h0155_0005, 32'h01FF_1F1F, OFF_MASKED, 32'h00AA_1F1A},
    '{OFF_EOI, 32'hFFFF_FF3C, 32'h01FF_1F1F, OFF_EOI, 32'h0000_003C},
    '{OFF_TXCTL, 32'hFFFF_FFFF, 32'h01FF_1F1F, OFF_TXCTL, 32'h0000_0001},
    '{OFF_TXEOI, 32'h0000_015A, 32'h01FF_1F1F, OFF_TXEOI, 32'h0000_005A},
    '{8'h40, 32'hFFFF_FFFF, 32'h01FF_1F1F, 8'h40, 32'h0000_0000},
    '{OFF_MSET, 32'hFFFF_FFFF, 32'h01FF_1F1F, OFF_MSET, 32'h0000_0000}};

  assign hready = hreadyout;
  always #4 mclk = ~mclk;

  uiet_regs uiet_regs_i (.mclk(mclk), .rst(rst), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .coreSrc(src[24:16]), .rxSrc(src[12:8]),
    .txSrc(src[4:0]), .irqVecIn(irqVecIn), .dmaVecIn(dmaVecIn),
    .irqPulse(irqPulse), .eoiWrite(eoiWrite), .eoiVec(eoiVec),
    .txDmaOn(txDmaOn), .tdReq(tdReq), .tdChan(tdChan), .tdDone(tdDone),
    .dmaEoiWrite(dmaEoiWrite), .dmaEoiVec(dmaEoiVec));

  uiet_dma_model uiet_dma_model_i (.mclk(mclk), .rst(rst), .tdReq(tdReq),
    .tdDone(tdDone));

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic summarize();
    if (miscompares == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] ex);
    checksDone++;
    if (seen !== ex)
    begin
      $display("mismatch %s expected %h seen %h", name, ex, seen);
      miscompares++;
    end
  endtask

  task automatic waitRdy();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    haddr <= {24'h00_0000, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
  endtask

  task automatic busRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    haddr <= {24'h00_0000, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    waitRdy();
    htrans <= 2'h0;
    waitRdy();
    d = hrdata;
    check("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] ex,
    input string name);
    logic [31:0] d;
    busRead(a, d);
    check(name, d, ex);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [31:0] d;
    int n;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    hsel <= 1'b1;
    rdChk(OFF_TDOWN, 32'h8000_0000, "tdown reset");
    foreach (ROWS[i])
    begin
      @(posedge mclk);
      src <= ROWS[i].s;
      busWrite(ROWS[i].wa, ROWS[i].wd);
      rdChk(ROWS[i].ra, ROWS[i].ex, $sformatf("row %0d", i));
    end
    check("txDmaOn", {31'h0000_0000, txDmaOn}, 32'h0000_0001);
    irqVecIn <= 32'hDEAD_BEEF;
    dmaVecIn <= 32'h0123_4567;
    rdChk(OFF_IVEC, 32'hDEAD_BEEF, "irq vector");
    rdChk(OFF_TXVEC, 32'h0123_4567, "dma vector");
    busWrite(OFF_TXCTL, 32'h0000_0000);
    #1;
    check("txDmaOn off", {31'h0000_0000, txDmaOn}, 32'h0000_0000);
    busWrite(OFF_EOI, 32'h0000_00A5);
    #1;
    check("eoiWrite", {31'h0000_0000, eoiWrite}, 32'h0000_0001);
    check("eoiVec", {24'h00_0000, eoiVec}, 32'h0000_00A5);
    @(posedge mclk);
    #1;
    check("eoiWrite end", {31'h0000_0000, eoiWrite}, 32'h0000_0000);
    check("irq after ack", {31'h0000_0000, irqPulse}, 32'h0000_0001);
    busWrite(OFF_TXEOI, 32'hFFFF_FFC3);
    #1;
    check("dmaEoiWrite", {31'h0000_0000, dmaEoiWrite}, 32'h0000_0001);
    check("dmaEoiVec", {24'h00_0000, dmaEoiVec}, 32'h0000_00C3);
    @(posedge mclk);
    #1;
    check("dmaEoiWrite end", {31'h0000_0000, dmaEoiWrite}, 32'h0000_0000);
    for (int c = 0; c < 4; c++)
    begin
      busWrite(OFF_TDOWN, {30'h3FFF_FFFF, c[1:0]});
      #1;
      check("tdReq", {31'h0000_0000, tdReq}, 32'h0000_0001);
      check("tdChan", {30'h0000_0000, tdChan}, c);
      rdChk(OFF_TDOWN, c, "tdown busy");
      busWrite(OFF_TDOWN, {30'h0000_0000, ~c[1:0]});
      #1;
      check("tdReq busy", {31'h0000_0000, tdReq}, 32'h0000_0000);
      check("tdChan kept", {30'h0000_0000, tdChan}, c);
      n = 0;
      do
      begin
        busRead(OFF_TDOWN, d);
        n++;
      end
      while (d[31] !== 1'b1 && n < 20);
      if (d[31] !== 1'b1)
      begin
        miscompares++;
        summarize();
      end
      check("tdown ready", d, 32'h8000_0000 | c);
    end
    busWrite(OFF_TXCTL, 32'h0000_0001);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check("txDmaOn rst", {31'h0000_0000, txDmaOn}, 32'h0000_0000);
    check("eoiVec rst", {24'h00_0000, eoiVec}, 32'h0000_0000);
    rdChk(OFF_MASKED, 32'h0000_0000, "mask rst");
    rdChk(OFF_TDOWN, 32'h8000_0000, "tdown rst");
    busWrite(OFF_MSET, 32'h0000_0001);
    #1;
    check("irq pre", {31'h0000_0000, irqPulse}, 32'h0000_0000);
    @(posedge mclk);
    #1;
    check("irq rise", {31'h0000_0000, irqPulse}, 32'h0000_0001);
    @(posedge mclk);
    #1;
    check("irq once", {31'h0000_0000, irqPulse}, 32'h0000_0000);
    summarize();
  end
endmodule

/* File: bench/uiet_dma_model.sv */
// Behavioural transmit DMA logic answering teardown requests
`timescale 1ns/1ps
module uiet_dma_model #(
  parameter int LAT = 12
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Teardown handshake
  input wire logic tdReq,
  output logic tdDone
);
  int cnt;
  // Teardown finishes LAT+1 cycles after its request
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt <= 0;
      tdDone <= 1'b0;
    end
    else
    begin
      tdDone <= (cnt == 1);
      if (tdReq)
        cnt <= LAT;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule

/* File: design/uiet_ahb_front.sv */
// AHB-Lite slave front end: address phase capture and write strobe
`timescale 1ns/1ps
module uiet_ahb_front
  import uiet_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  // Register side
  output logic wrEn,
  output logic [ADDR_W-1:0] wrAddr,
  output logic rdAcc,
  output logic [ADDR_W-1:0] rdAddr
);

  // ************************************************************
  // State
  // ************************************************************
  uiet_front_s st_r;
  uiet_front_s st_nxt;
  logic active;

  assign active = hsel && htrans[TRANS_ACT_BIT] && hready && ce;

  always_comb
  begin
    st_nxt = st_r;
    if (hready && ce)
    begin
      st_nxt.wrPend = active && hwrite;
      st_nxt.wrAddr = haddr[ADDR_W-1:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st_r <= FRONT_RST;
    else if (ce)
      st_r <= st_nxt;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign hreadyout = ce;
  assign hresp = HRESP_OKAY;
  assign wrEn = st_r.wrPend && ce;
  assign wrAddr = st_r.wrAddr;
  assign rdAcc = active && !hwrite;
  assign rdAddr = haddr[ADDR_W-1:0];

endmodule

/* File: design/uiet_regs.sv */
// Interrupt status, end-of-interrupt and transmit DMA control registers
//
// Functional notes
// - Core field of masked status is core sources ANDed with masks.
// - Receive and transmit fields of masked status are masked likewise.
// - Writing the acknowledge register emits an acknowledge strobe.
// - That write stores the written 8-bit acknowledge vector exactly.
// - After an acknowledge, pending enabled sources raise a new interrupt.
// - Read-only 32-bit vector register shows the interrupt vector input.
// - Transmit DMA enable bit zero: 0 disables, 1 enables.
// - Teardown top bit is a read-only ready flag, reset to one.
// - Teardown write takes a 2-bit channel number, 0 to 3.
// - One cycle after a DMA acknowledge write the vector appears.
// - With that vector the DMA strobe is high one cycle.
// - DMA acknowledge turns level conditions into single pulsed events.
// - DMA vector register holds a registered copy of its input.
// - Writing ones to mask-set sets those mask bits.
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module uiet_regs
  import uiet_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Interrupt sources and vectors
  input wire logic [CORE_W-1:0] coreSrc,
  input wire logic [RX_W-1:0] rxSrc,
  input wire logic [TX_W-1:0] txSrc,
  input wire logic [31:0] irqVecIn,
  input wire logic [31:0] dmaVecIn,
  // Interrupt controller side
  output logic irqPulse,
  output logic eoiWrite,
  output logic [VEC_W-1:0] eoiVec,
  // Transmit DMA side
  output logic txDmaOn,
  output logic tdReq,
  output logic [CHAN_W-1:0] tdChan,
  input wire logic tdDone,
  output logic dmaEoiWrite,
  output logic [VEC_W-1:0] dmaEoiVec
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic regHit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] off
  );
    return a == off;
  endfunction

  function automatic logic [31:0] maskWord(input logic [SRC_W-1:0] v);
    logic [31:0] w;
    w = '0;
    w[CORE_LSB +: CORE_W] = v[SRC_CORE_LSB +: CORE_W];
    w[RX_LSB +: RX_W] = v[SRC_RX_LSB +: RX_W];
    w[TX_LSB +: TX_W] = v[SRC_TX_LSB +: TX_W];
    return w;
  endfunction

  function automatic logic [SRC_W-1:0] srcField(input logic [31:0] w);
    logic [SRC_W-1:0] v;
    v = '0;
    v[SRC_CORE_LSB +: CORE_W] = w[CORE_LSB +: CORE_W];
    v[SRC_RX_LSB +: RX_W] = w[RX_LSB +: RX_W];
    v[SRC_TX_LSB +: TX_W] = w[TX_LSB +: TX_W];
    return v;
  endfunction

  // ************************************************************
  // Bus front end
  // ************************************************************
  logic wrEn;
  logic rdAcc;
  logic [ADDR_W-1:0] wrAddr;
  logic [ADDR_W-1:0] rdAddr;

  uiet_ahb_front u_front (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .rdAcc(rdAcc),
    .rdAddr(rdAddr)
  );

  // ************************************************************
  // State
  // ************************************************************
  uiet_regs_s st_r;
  uiet_regs_s st_nxt;
  logic [SRC_W-1:0] srcAll;
  logic [SRC_W-1:0] masked;
  logic anyMasked;
  logic [31:0] rdVal;

  assign srcAll = {coreSrc, rxSrc, txSrc};
  assign masked = srcAll & st_r.mask;
  assign anyMasked = |masked;

  // Read mux, unmapped and write-only offsets read zero
  always_comb
  begin
    rdVal = '0;
    if (regHit(rdAddr, OFF_MASKED))
      rdVal = maskWord(masked);
    else if (regHit(rdAddr, OFF_EOI))
      rdVal[VEC_W-1:0] = st_r.eoiVec;
    else if (regHit(rdAddr, OFF_IVEC))
      rdVal = st_r.irqVec;
    else if (regHit(rdAddr, OFF_TXCTL))
      rdVal[ON_BIT] = st_r.txOn;
    else if (regHit(rdAddr, OFF_TDOWN))
    begin
      rdVal[READY_BIT] = (st_r.td == TD_READY);
      rdVal[CHAN_W-1:0] = st_r.tdChan;
    end
    else if (regHit(rdAddr, OFF_TXEOI))
      rdVal[VEC_W-1:0] = st_r.dmaEoiVec;
    else if (regHit(rdAddr, OFF_TXVEC))
      rdVal = st_r.dmaVec;
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.eoiWrite = 1'b0;
    st_nxt.tdReq = 1'b0;
    st_nxt.dmaEoiWrite = 1'b0;
    st_nxt.irqVec = irqVecIn;
    st_nxt.dmaVec = dmaVecIn;
    st_nxt.prevAny = anyMasked;
    // New pending source, or still pending after an acknowledge
    st_nxt.irqPulse = (anyMasked && !st_r.prevAny) ||
                      (st_r.eoiWrite && anyMasked);
    if (rdAcc)
      st_nxt.rdata = rdVal;
    unique case (st_r.td)
      TD_READY:
      begin
        if (wrEn && regHit(wrAddr, OFF_TDOWN))
        begin
          st_nxt.tdChan = hwdata[CHAN_W-1:0];
          st_nxt.tdReq = 1'b1;
          st_nxt.td = TD_BUSY;
        end
      end
      TD_BUSY:
      begin
        // Writes while busy are dropped
        if (tdDone)
          st_nxt.td = TD_READY;
      end
    endcase
    if (wrEn)
    begin
      if (regHit(wrAddr, OFF_EOI))
      begin
        st_nxt.eoiWrite = 1'b1;
        st_nxt.eoiVec = hwdata[VEC_W-1:0];
      end
      if (regHit(wrAddr, OFF_TXCTL))
        st_nxt.txOn = hwdata[ON_BIT];
      if (regHit(wrAddr, OFF_TXEOI))
      begin
        st_nxt.dmaEoiWrite = 1'b1;
        st_nxt.dmaEoiVec = hwdata[VEC_W-1:0];
      end
      if (regHit(wrAddr, OFF_MSET))
        st_nxt.mask = st_r.mask | srcField(hwdata);
      if (regHit(wrAddr, OFF_MCLR))
        st_nxt.mask = st_r.mask & ~srcField(hwdata);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st_r <= REGS_RST;
    else if (ce)
      st_r <= st_nxt;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign hrdata = st_r.rdata;
  assign irqPulse = st_r.irqPulse;
  assign eoiWrite = st_r.eoiWrite;
  assign eoiVec = st_r.eoiVec;
  assign txDmaOn = st_r.txOn;
  assign tdReq = st_r.tdReq;
  assign tdChan = st_r.tdChan;
  assign dmaEoiWrite = st_r.dmaEoiWrite;
  assign dmaEoiVec = st_r.dmaEoiVec;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  logic tdWrOk;
  logic tdWrBusy;
  logic dmaWr;
  assign tdWrOk = wrEn && regHit(wrAddr, OFF_TDOWN) && st_r.td == TD_READY;
  assign tdWrBusy = wrEn && regHit(wrAddr, OFF_TDOWN) && st_r.td == TD_BUSY;
  assign dmaWr = wrEn && regHit(wrAddr, OFF_TXEOI);

  sequence dmaPulseSeq(logic [VEC_W-1:0] v);
    dmaEoiWrite && dmaEoiVec == v ##1 (!dmaEoiWrite || $past(dmaWr));
  endsequence

  core_masked_a: assert property (
    rdAcc && regHit(rdAddr, OFF_MASKED) |=>
      hrdata[CORE_LSB +: CORE_W] ==
      ($past(coreSrc) & $past(st_r.mask[SRC_CORE_LSB +: CORE_W])))
    else $error("core masked status wrong");

  ep_masked_a: assert property (
    rdAcc && regHit(rdAddr, OFF_MASKED) |=>
      hrdata[RX_LSB +: RX_W] == $past(masked[SRC_RX_LSB +: RX_W]) &&
      hrdata[TX_LSB +: TX_W] == $past(masked[SRC_TX_LSB +: TX_W]))
    else $error("endpoint masked status wrong");

  rsvd_zero_a: assert property (
    rdAcc && regHit(rdAddr, OFF_MASKED) |=>
      (hrdata >> (CORE_LSB + CORE_W)) == '0 &&
      hrdata[CORE_LSB-1:RX_LSB+RX_W] == '0 &&
      hrdata[RX_LSB-1:TX_LSB+TX_W] == '0)
    else $error("reserved masked bits not zero");

  eoi_strobe_a: assert property (
    wrEn && regHit(wrAddr, OFF_EOI) |=> eoiWrite)
    else $error("acknowledge strobe missing");

  eoi_vector_a: assert property (
    wrEn && regHit(wrAddr, OFF_EOI) |=>
      eoiVec == $past(hwdata[VEC_W-1:0]) ##1 $stable(eoiVec) ||
      $past(wrEn))
    else $error("acknowledge vector not stored");

  eoi_reraise_a: assert property (
    eoiWrite && anyMasked && ce |=> irqPulse)
    else $error("no interrupt after acknowledge");

  vec_copy_a: assert property (
    ce |=> st_r.irqVec == $past(irqVecIn))
    else $error("interrupt vector not copied");

  dma_vec_a: assert property (
    rdAcc && regHit(rdAddr, OFF_TXVEC) && $past(ce) && !$past(rst) |=>
      hrdata == $past(dmaVecIn, 2))
    else $error("dma vector readback wrong");

  dma_on_a: assert property (
    wrEn && regHit(wrAddr, OFF_TXCTL) |=>
      txDmaOn == $past(hwdata[ON_BIT]))
    else $error("dma enable not written");

  td_ready_a: assert property (
    tdWrOk |=> st_r.td == TD_BUSY && tdReq ##1 (!tdReq || !ce))
    else $error("teardown ready flag wrong");

  td_chan_a: assert property (
    tdWrOk |=> tdChan == $past(hwdata[CHAN_W-1:0]))
    else $error("teardown channel wrong");

  td_busy_a: assert property (
    tdWrBusy |=> $stable(tdChan) && !tdReq)
    else $error("teardown write taken while busy");

  dma_eoi_a: assert property (
    dmaWr ##1 ce |-> dmaPulseSeq($past(hwdata[VEC_W-1:0])))
    else $error("dma acknowledge pulse wrong");

  dma_cause_a: assert property (
    dmaEoiWrite && ce |-> $past(dmaWr))
    else $error("dma acknowledge pulse without write");

  mask_set_a: assert property (
    wrEn && regHit(wrAddr, OFF_MSET) && !$past(rst) |=>
      (st_r.mask & $past(srcField(hwdata))) == $past(srcField(hwdata)))
    else $error("mask set did not set bits");

  ivec_read_a: assert property (
    rdAcc && regHit(rdAddr, OFF_IVEC) && $past(ce) && !$past(rst) |=>
      hrdata == $past(irqVecIn, 2))
    else $error("interrupt vector readback wrong");

  irq_rise_a: assert property (
    anyMasked && !st_r.prevAny && ce |=> irqPulse)
    else $error("no interrupt on new pending source");

  irq_cause_a: assert property (
    $past(ce) && irqPulse |-> $past(anyMasked))
    else $error("interrupt without pending source");

  td_reset_a: assert property (
    $past(rst) |-> st_r.td == TD_READY && !tdReq)
    else $error("teardown not ready after reset");

  td_flag_a: assert property (
    rdAcc && regHit(rdAddr, OFF_TDOWN) && st_r.td == TD_BUSY |=>
      !hrdata[READY_BIT])
    else $error("teardown ready flag set while busy");

  ctl_rsvd_a: assert property (
    rdAcc && regHit(rdAddr, OFF_TXCTL) |=> (hrdata >> (ON_BIT + 1)) == '0)
    else $error("control reserved bits not zero");

  eoi_rsvd_a: assert property (
    rdAcc && regHit(rdAddr, OFF_EOI) |=> (hrdata >> VEC_W) == '0)
    else $error("acknowledge reserved bits not zero");

  td_rsvd_a: assert property (
    rdAcc && regHit(rdAddr, OFF_TDOWN) |=>
      hrdata[READY_BIT-1:CHAN_W] == '0)
    else $error("teardown reserved bits not zero");

endmodule

/* File: shared/uiet_pkg.sv */
// Shared constants and types for the interrupt and transmit DMA register block
package uiet_pkg;

  // ************************************************************
  // Address map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_MASKED = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EOI = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IVEC = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TXCTL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_TDOWN = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_TXEOI = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_TXVEC = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_MSET = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_MCLR = 8'h20;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int CORE_LSB = 16;
  localparam int CORE_W = 9;
  localparam int RX_LSB = 8;
  localparam int RX_W = 5;
  localparam int TX_LSB = 0;
  localparam int TX_W = 5;
  localparam int SRC_W = CORE_W + RX_W + TX_W;
  localparam int SRC_TX_LSB = 0;
  localparam int SRC_RX_LSB = TX_W;
  localparam int SRC_CORE_LSB = TX_W + RX_W;
  localparam int VEC_W = 8;
  localparam int CHAN_W = 2;
  localparam int ON_BIT = 0;
  localparam int READY_BIT = 31;
  localparam int TRANS_ACT_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic {TD_READY, TD_BUSY} uiet_td_e;

  typedef struct packed {
    logic wrPend;
    logic [ADDR_W-1:0] wrAddr;
  } uiet_front_s;

  typedef struct packed {
    logic [SRC_W-1:0] mask;
    logic prevAny;
    logic irqPulse;
    logic eoiWrite;
    logic [VEC_W-1:0] eoiVec;
    logic [31:0] irqVec;
    logic [31:0] dmaVec;
    logic txOn;
    uiet_td_e td;
    logic tdReq;
    logic [CHAN_W-1:0] tdChan;
    logic dmaEoiWrite;
    logic [VEC_W-1:0] dmaEoiVec;
    logic [31:0] rdata;
  } uiet_regs_s;

  localparam uiet_front_s FRONT_RST = '{wrPend: 1'b0, wrAddr: '0};
  localparam uiet_regs_s REGS_RST = '{
    mask: '0, prevAny: 1'b0, irqPulse: 1'b0, eoiWrite: 1'b0,
    eoiVec: '0, irqVec: '0, dmaVec: '0, txOn: 1'b0, td: TD_READY,
    tdReq: 1'b0, tdChan: '0, dmaEoiWrite: 1'b0, dmaEoiVec: '0,
    rdata: '0};

endpackage
